// ### common/fahp_pkg.sv
// package: constants shared by the frame aligner host port ends
package fahp_pkg;
   localparam int ADDR_W = 4;
   localparam int DATA_W = 8;
   localparam int NUM_REGS = 16;
   // register offsets
   localparam logic [3:0] MODE_ADDR = 4'h0;
   localparam logic [3:0] CTRL_ADDR = 4'h1;
   localparam logic [3:0] STACK_STAT_ADDR = 4'hE;
   localparam logic [3:0] LINE_STAT_ADDR = 4'hF;
   // field positions
   localparam int MODE_RATE_BIT = 0;
   localparam int CTRL_STACK_BIT = 0;
   localparam int STAT_COS_BIT = 0;
   localparam int STAT_RATE_BIT = 1;
   localparam logic [7:0] REG_RESET = 8'h00;
   // signaling stacks
   localparam int STACK_DEPTH = 4;
   localparam int STACK_PTR_W = 2;
   localparam int STACK_CNT_W = 3;
   // clocks
   localparam int SYS_CLK_KHZ = 125000;
   localparam int SCLK_SLOW_KHZ = 4096;
   localparam int SCLK_FAST_KHZ = 8192;
   localparam int ROUTE_E1_KHZ = 2048;
   localparam int ROUTE_T1_KHZ = 1544;
   // half period of the route clock, rounded down
   localparam int ROUTE_HALF_E1 = SYS_CLK_KHZ / (2 * ROUTE_E1_KHZ);
   localparam int ROUTE_HALF_T1 = SYS_CLK_KHZ / (2 * ROUTE_T1_KHZ);
   localparam int ROUTE_CNT_W = 6;
   // host strobe timing in cycles
   localparam int SETUP_CYCLES = 1;
   localparam int STROBE_CYCLES = 4;
   localparam int HOLD_CYCLES = 1;
   localparam int HOST_CNT_W = 3;
endpackage : fahp_pkg

// ### common/fahp_if.sv
// interface: parallel host bus between host end and device end
`timescale 1ns/1ps
interface fahp_if;
   logic [3:0] addr;
   logic chip_select_n;
   logic read_strobe_n;
   logic write_strobe_n;
   logic stack_ack_n;
   logic [7:0] host_data_out;
   logic host_data_oe;
   logic [7:0] dev_data_out;
   logic dev_data_oe;
   logic [7:0] data;
   logic rx_route_clock;
   // resolved bus level; an undriven bus floats high
   assign data = dev_data_oe ? dev_data_out : (host_data_oe ? host_data_out : 8'hFF);
   modport host (output addr, output chip_select_n, output read_strobe_n, output write_strobe_n,
                 output stack_ack_n, output host_data_out, output host_data_oe, output rx_route_clock,
                 input data);
   modport device (input addr, input chip_select_n, input read_strobe_n, input write_strobe_n,
                   input stack_ack_n, output dev_data_out, output dev_data_oe, input rx_route_clock,
                   input data);
endinterface : fahp_if

// ### hdl/fahp_device.sv
// device end: register file, signaling stacks, AIS line output
`timescale 1ns/1ps
// Behaviour
// (R01) four address lines select one register
// (R02) host never writes addresses 0E, 0F
// (R03) chip select plus read drives register data
// (R04) stack enabled: ack plus read gives rx stack
// (R05) chip select plus write stores bus data
// (R06) stack enabled: ack plus write fills tx stack
// (R07) out of service sends unframed all ones
// (R08) mode bit tells which system clock rate
// (R09) host supplies route clock, E1 2048, T1 1544; the host divider gives about 2083 and 1562
// (R10) device drives data only during reads
// (R11) writes to 0E, 0F are ignored
module fahp_device (
   input wire logic sys_clk_i,
   input wire logic resetn_i,
   fahp_if.device bus,
   input wire logic cos_i,
   input wire logic tx_data_plus_i,
   input wire logic tx_data_minus_i,
   input wire logic tx_data_optical_i,
   input wire logic rx_sig_valid_i,
   input wire logic [fahp_pkg::DATA_W-1:0] rx_sig_data_i,
   output logic rx_sig_ready_o,
   output logic tx_sig_valid_o,
   output logic [fahp_pkg::DATA_W-1:0] tx_sig_data_o,
   input wire logic tx_sig_ready_i,
   output logic sclk_rate_fast_o,
   output logic stack_access_enable_o,
   output logic bit_strobe_o,
   output logic tx_line_plus_o,
   output logic tx_line_minus_o,
   output logic tx_optical_data_o
);
   import fahp_pkg::*;

   logic [7:0] regs_q [0:NUM_REGS-1];
   logic [7:0] regs_d [0:NUM_REGS-1];
   logic [7:0] rx_stack_q [0:STACK_DEPTH-1];
   logic [7:0] rx_stack_d [0:STACK_DEPTH-1];
   logic [7:0] tx_stack_q [0:STACK_DEPTH-1];
   logic [7:0] tx_stack_d [0:STACK_DEPTH-1];
   logic [STACK_PTR_W-1:0] rx_wp_q, rx_wp_d, rx_rp_q, rx_rp_d;
   logic [STACK_PTR_W-1:0] tx_wp_q, tx_wp_d, tx_rp_q, tx_rp_d;
   logic [STACK_CNT_W-1:0] rx_cnt_q, rx_cnt_d, tx_cnt_q, tx_cnt_d;
   logic [7:0] rdata_q, rdata_d;
   logic oe_q, oe_d;
   logic stk_rd_q, stk_rd_d;
   logic stk_wr_q, stk_wr_d;
   logic reg_rd, reg_wr, stk_rd, stk_wr;
   logic stk_en;
   logic rx_push, rx_pop, tx_push, tx_pop;
   logic route_s1_q, route_s2_q, route_s3_q;
   logic line_p_q, line_p_d, line_m_q, line_m_d, opt_q, opt_d;
   logic ais_pol_q, ais_pol_d;
   logic fall_edge;

   // bus cycle decode; chip select and ack paths are separate
   assign stk_en = regs_q[CTRL_ADDR][CTRL_STACK_BIT];
   assign reg_rd = !bus.chip_select_n && !bus.read_strobe_n; // (R03)
   assign reg_wr = !bus.chip_select_n && !bus.write_strobe_n; // (R05)
   assign stk_rd = stk_en && !bus.stack_ack_n && !bus.read_strobe_n; // (R04)
   assign stk_wr = stk_en && !bus.stack_ack_n && !bus.write_strobe_n; // (R06)

   // stack moves happen once per strobe: pop at read end, push at write end
   assign rx_pop = stk_rd_q && !stk_rd && (rx_cnt_q != '0);
   assign tx_push = stk_wr_q && !stk_wr && (tx_cnt_q != STACK_CNT_W'(STACK_DEPTH));
   assign rx_push = rx_sig_valid_i && rx_sig_ready_o;
   assign tx_pop = tx_sig_valid_o && tx_sig_ready_i;
   assign rx_sig_ready_o = (rx_cnt_q != STACK_CNT_W'(STACK_DEPTH));
   assign tx_sig_valid_o = (tx_cnt_q != '0);
   assign tx_sig_data_o = tx_stack_q[tx_rp_q];

   // register file, read data and stack bookkeeping
   always_comb begin
      for (int i = 0; i < NUM_REGS; i++) begin
         regs_d[i] = regs_q[i];
      end
      for (int i = 0; i < STACK_DEPTH; i++) begin
         rx_stack_d[i] = rx_stack_q[i];
         tx_stack_d[i] = tx_stack_q[i];
      end
      // status registers always mirror live state, so writes there have no effect
      regs_d[STACK_STAT_ADDR] = {1'b0, rx_cnt_q, 1'b0, tx_cnt_q}; // (R11)
      regs_d[LINE_STAT_ADDR] = {6'h00, regs_q[MODE_ADDR][MODE_RATE_BIT], cos_i};
      if (reg_wr && (bus.addr != STACK_STAT_ADDR) && (bus.addr != LINE_STAT_ADDR)) begin // (R02) (R11)
         regs_d[bus.addr] = bus.data; // (R01) (R05)
      end
      stk_rd_d = stk_rd;
      stk_wr_d = stk_wr;
      // tx stack word is captured from the bus during the strobe; a full stack keeps its head intact
      if (stk_wr && (tx_cnt_q != STACK_CNT_W'(STACK_DEPTH))) begin
         tx_stack_d[tx_wp_q] = bus.data; // (R06)
      end
      if (rx_push) begin
         rx_stack_d[rx_wp_q] = rx_sig_data_i;
      end
      rx_wp_d = rx_push ? rx_wp_q + 1'b1 : rx_wp_q;
      rx_rp_d = rx_pop ? rx_rp_q + 1'b1 : rx_rp_q;
      tx_wp_d = tx_push ? tx_wp_q + 1'b1 : tx_wp_q;
      tx_rp_d = tx_pop ? tx_rp_q + 1'b1 : tx_rp_q;
      rx_cnt_d = rx_cnt_q + STACK_CNT_W'(rx_push) - STACK_CNT_W'(rx_pop);
      tx_cnt_d = tx_cnt_q + STACK_CNT_W'(tx_push) - STACK_CNT_W'(tx_pop);
      // the bus is driven only while a read is active
      oe_d = reg_rd || stk_rd; // (R10)
      rdata_d = 8'h00;
      if (stk_rd) begin
         rdata_d = rx_stack_q[rx_rp_q]; // (R04)
      end else if (reg_rd) begin
         rdata_d = regs_q[bus.addr]; // (R01) (R03)
      end
   end

   always_ff @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         for (int i = 0; i < NUM_REGS; i++) begin
            regs_q[i] <= REG_RESET;
         end
         for (int i = 0; i < STACK_DEPTH; i++) begin
            rx_stack_q[i] <= 8'h00;
            tx_stack_q[i] <= 8'h00;
         end
         rx_wp_q <= '0;
         rx_rp_q <= '0;
         tx_wp_q <= '0;
         tx_rp_q <= '0;
         rx_cnt_q <= '0;
         tx_cnt_q <= '0;
         rdata_q <= 8'h00;
         oe_q <= 1'b0;
         stk_rd_q <= 1'b0;
         stk_wr_q <= 1'b0;
      end else begin
         for (int i = 0; i < NUM_REGS; i++) begin
            regs_q[i] <= regs_d[i];
         end
         for (int i = 0; i < STACK_DEPTH; i++) begin
            rx_stack_q[i] <= rx_stack_d[i];
            tx_stack_q[i] <= tx_stack_d[i];
         end
         rx_wp_q <= rx_wp_d;
         rx_rp_q <= rx_rp_d;
         tx_wp_q <= tx_wp_d;
         tx_rp_q <= tx_rp_d;
         rx_cnt_q <= rx_cnt_d;
         tx_cnt_q <= tx_cnt_d;
         rdata_q <= rdata_d;
         oe_q <= oe_d;
         stk_rd_q <= stk_rd_d;
         stk_wr_q <= stk_wr_d;
      end
   end

   assign bus.dev_data_out = rdata_q;
   assign bus.dev_data_oe = oe_q; // (R10)
   assign sclk_rate_fast_o = regs_q[MODE_ADDR][MODE_RATE_BIT]; // (R08)
   assign stack_access_enable_o = stk_en;

   // route clock synchroniser; only the second and third stages feed the edge detect
   always_ff @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         route_s1_q <= 1'b0;
         route_s2_q <= 1'b0;
         route_s3_q <= 1'b0;
      end else begin
         route_s1_q <= bus.rx_route_clock;
         route_s2_q <= route_s1_q;
         route_s3_q <= route_s2_q;
      end
   end
   // a falling route clock edge marks one line bit; it relies on the host's clock
   assign fall_edge = route_s3_q && !route_s2_q; // (R09)
   assign bit_strobe_o = fall_edge;

   // line output: framer data, or unframed all ones with alternating marks when out of service
   always_comb begin
      line_p_d = line_p_q;
      line_m_d = line_m_q;
      opt_d = opt_q;
      ais_pol_d = ais_pol_q;
      if (fall_edge) begin
         if (cos_i) begin
            line_p_d = !ais_pol_q; // (R07)
            line_m_d = ais_pol_q; // (R07)
            opt_d = 1'b1; // (R07)
            ais_pol_d = !ais_pol_q;
         end else begin
            line_p_d = tx_data_plus_i;
            line_m_d = tx_data_minus_i;
            opt_d = tx_data_optical_i;
         end
      end
   end

   always_ff @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         line_p_q <= 1'b0;
         line_m_q <= 1'b0;
         opt_q <= 1'b0;
         ais_pol_q <= 1'b0;
      end else begin
         line_p_q <= line_p_d;
         line_m_q <= line_m_d;
         opt_q <= opt_d;
         ais_pol_q <= ais_pol_d;
      end
   end

   assign tx_line_plus_o = line_p_q;
   assign tx_line_minus_o = line_m_q;
   assign tx_optical_data_o = opt_q;
endmodule : fahp_device

// ### hdl/fahp_host.sv
// host end: bus cycle sequencer and route clock source
`timescale 1ns/1ps
module fahp_host (
   input wire logic sys_clk_i,
   input wire logic resetn_i,
   fahp_if.host bus,
   input wire logic e1_mode_i,
   input wire logic cmd_valid_i,
   input wire logic cmd_write_i,
   input wire logic cmd_stack_i,
   input wire logic [fahp_pkg::ADDR_W-1:0] cmd_addr_i,
   input wire logic [fahp_pkg::DATA_W-1:0] cmd_wdata_i,
   output logic cmd_ready_o,
   output logic rsp_valid_o,
   output logic rsp_error_o,
   output logic [fahp_pkg::DATA_W-1:0] rsp_rdata_o
);
   import fahp_pkg::*;

   typedef enum logic [1:0] {ST_IDLE, ST_SETUP, ST_STROBE, ST_HOLD} fahp_state_type;
   fahp_state_type state_q, state_d;
   logic [HOST_CNT_W-1:0] cnt_q, cnt_d;
   logic wr_q, wr_d, stk_q, stk_d;
   logic [3:0] addr_q, addr_d;
   logic [7:0] wdata_q, wdata_d, rdata_q, rdata_d;
   logic rsp_q, rsp_d, err_q, err_d;
   logic [ROUTE_CNT_W-1:0] rc_cnt_q, rc_cnt_d;
   logic rclk_q, rclk_d;
   logic bad_write;

   assign cmd_ready_o = (state_q == ST_IDLE);
   assign bad_write = cmd_write_i && !cmd_stack_i && (cmd_addr_i[3:1] == STACK_STAT_ADDR[3:1]);

   // cycle sequencer: setup, strobe, hold
   always_comb begin
      state_d = state_q;
      cnt_d = cnt_q;
      wr_d = wr_q;
      stk_d = stk_q;
      addr_d = addr_q;
      wdata_d = wdata_q;
      rdata_d = rdata_q;
      rsp_d = 1'b0;
      err_d = 1'b0;
      case (state_q)
         ST_IDLE: begin
            if (cmd_valid_i) begin
               if (bad_write) begin
                  rsp_d = 1'b1; // (R02)
                  err_d = 1'b1;
               end else begin
                  wr_d = cmd_write_i;
                  stk_d = cmd_stack_i;
                  addr_d = cmd_addr_i;
                  wdata_d = cmd_wdata_i;
                  cnt_d = HOST_CNT_W'(SETUP_CYCLES - 1);
                  state_d = ST_SETUP;
               end
            end
         end
         ST_SETUP: begin
            if (cnt_q == '0) begin
               cnt_d = HOST_CNT_W'(STROBE_CYCLES - 1);
               state_d = ST_STROBE;
            end else begin
               cnt_d = cnt_q - 1'b1;
            end
         end
         ST_STROBE: begin
            if (cnt_q == '0) begin
               rdata_d = wr_q ? 8'h00 : bus.data; // (R03) (R04)
               cnt_d = HOST_CNT_W'(HOLD_CYCLES - 1);
               state_d = ST_HOLD;
            end else begin
               cnt_d = cnt_q - 1'b1;
            end
         end
         ST_HOLD: begin
            if (cnt_q == '0) begin
               rsp_d = 1'b1;
               state_d = ST_IDLE;
            end else begin
               cnt_d = cnt_q - 1'b1;
            end
         end
         default: begin
            state_d = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         state_q <= ST_IDLE;
         cnt_q <= '0;
         wr_q <= 1'b0;
         stk_q <= 1'b0;
         addr_q <= 4'h0;
         wdata_q <= 8'h00;
         rdata_q <= 8'h00;
         rsp_q <= 1'b0;
         err_q <= 1'b0;
      end else begin
         state_q <= state_d;
         cnt_q <= cnt_d;
         wr_q <= wr_d;
         stk_q <= stk_d;
         addr_q <= addr_d;
         wdata_q <= wdata_d;
         rdata_q <= rdata_d;
         rsp_q <= rsp_d;
         err_q <= err_d;
      end
   end

   // address and select stand through setup, strobe and hold
   assign bus.addr = addr_q; // (R01)
   assign bus.chip_select_n = !((state_q != ST_IDLE) && !stk_q); // (R03) (R05)
   assign bus.stack_ack_n = !((state_q != ST_IDLE) && stk_q); // (R04) (R06)
   assign bus.read_strobe_n = !((state_q == ST_STROBE) && !wr_q);
   assign bus.write_strobe_n = !((state_q == ST_STROBE) && wr_q);
   // host drives data only around a write, never during a read
   assign bus.host_data_out = wdata_q;
   assign bus.host_data_oe = (state_q != ST_IDLE) && wr_q; // (R10)
   assign rsp_valid_o = rsp_q;
   assign rsp_error_o = err_q;
   assign rsp_rdata_o = rdata_q;

   // route clock divider; rates are rounded, a limitation of the 125 MHz base
   always_comb begin
      rc_cnt_d = rc_cnt_q + 1'b1;
      rclk_d = rclk_q;
      if (rc_cnt_q >= (e1_mode_i ? ROUTE_CNT_W'(ROUTE_HALF_E1 - 1) : ROUTE_CNT_W'(ROUTE_HALF_T1 - 1))) begin
         rc_cnt_d = '0;
         rclk_d = !rclk_q; // (R09)
      end
   end

   always_ff @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         rc_cnt_q <= '0;
         rclk_q <= 1'b0;
      end else begin
         rc_cnt_q <= rc_cnt_d;
         rclk_q <= rclk_d;
      end
   end

   assign bus.rx_route_clock = rclk_q;
endmodule : fahp_host

// ### test/fahp_checker.sv
// checker: host bus protocol assertions on the shared interface
`timescale 1ns/1ps
module fahp_checker (
   input wire logic sys_clk_i,
   input wire logic resetn_i,
   input wire logic [3:0] addr_i,
   input wire logic chip_select_n_i,
   input wire logic read_strobe_n_i,
   input wire logic write_strobe_n_i,
   input wire logic stack_ack_n_i,
   input wire logic host_data_oe_i,
   input wire logic dev_data_oe_i,
   input wire logic [7:0] dev_data_out_i
);
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!resetn_i);
   // a selected read makes the device drive the bus one cycle later
   property p_read_drive;
      !chip_select_n_i && !read_strobe_n_i |=> dev_data_oe_i;
   endproperty
   a_read_drive: assert property (p_read_drive) else $error("device silent in read");
   // device lets go once the read strobe has been idle two cycles
   property p_release;
      read_strobe_n_i [*2] |=> !dev_data_oe_i;
   endproperty
   a_release: assert property (p_release) else $error("device drives outside read");
   // two drivers on the bus at once would fight
   property p_no_fight;
      !(dev_data_oe_i && host_data_oe_i);
   endproperty
   a_no_fight: assert property (p_no_fight) else $error("bus contention");
   // read data must not wander while the host is still sampling it
   property p_data_hold;
      dev_data_oe_i && $past(dev_data_oe_i) && !read_strobe_n_i |-> $stable(dev_data_out_i);
   endproperty
   a_data_hold: assert property (p_data_hold) else $error("read data moved");
   // read-only status places never see a write cycle
   property p_no_status_write;
      !chip_select_n_i && !write_strobe_n_i |-> addr_i < 4'hE;
   endproperty
   a_no_status_write: assert property (p_no_status_write) else $error("write to status");
   // the write strobe is four cycles wide
   property p_wr_width;
      $fell(write_strobe_n_i) |-> !write_strobe_n_i [*4] ##1 write_strobe_n_i;
   endproperty
   a_wr_width: assert property (p_wr_width) else $error("write strobe width");
   // the read strobe is four cycles wide as well
   property p_rd_width;
      $fell(read_strobe_n_i) |-> !read_strobe_n_i [*4] ##1 read_strobe_n_i;
   endproperty
   a_rd_width: assert property (p_rd_width) else $error("read strobe width");
   // a strobe is always qualified by a chip select or a stack ack
   property p_strobe_sel;
      !write_strobe_n_i || !read_strobe_n_i |-> !chip_select_n_i || !stack_ack_n_i;
   endproperty
   a_strobe_sel: assert property (p_strobe_sel) else $error("unqualified strobe");
   // the device keeps off the bus while the host writes
   property p_quiet_in_write;
      !write_strobe_n_i |-> !dev_data_oe_i;
   endproperty
   a_quiet_in_write: assert property (p_quiet_in_write) else $error("device drives in write");
   // the address holds through the whole read strobe
   property p_addr_hold;
      !read_strobe_n_i && $past(!read_strobe_n_i) |-> $stable(addr_i);
   endproperty
   a_addr_hold: assert property (p_addr_hold) else $error("address moved");
endmodule : fahp_checker

// ### test/fahp_tb.sv
// testbench: host end and device end joined over the shared bus
`timescale 1ns/1ps
module fahp_tb;
   import fahp_pkg::*;
   logic sys_clk = 1'b0;
   logic resetn = 1'b0;
   logic e1, cv, cw, cst, cos, tp, tm, to, rsv, tsr;
   logic [3:0] ca;
   logic [7:0] cd, rsd;
   logic rdy, rv, re, rsr, tsv, fast, sae, bs, lp, lm, lo, p, r_err;
   logic [7:0] rdat, tsd, r_dat;
   int errors = 0;
   int total_checks = 0;
   fahp_if bus_if ();
   fahp_host fahp_host_inst (.sys_clk_i(sys_clk), .resetn_i(resetn), .bus(bus_if), .e1_mode_i(e1),
      .cmd_valid_i(cv), .cmd_write_i(cw), .cmd_stack_i(cst), .cmd_addr_i(ca), .cmd_wdata_i(cd),
      .cmd_ready_o(rdy), .rsp_valid_o(rv), .rsp_error_o(re), .rsp_rdata_o(rdat));
   fahp_device fahp_device_inst (.sys_clk_i(sys_clk), .resetn_i(resetn), .bus(bus_if), .cos_i(cos),
      .tx_data_plus_i(tp), .tx_data_minus_i(tm), .tx_data_optical_i(to), .rx_sig_valid_i(rsv),
      .rx_sig_data_i(rsd), .rx_sig_ready_o(rsr), .tx_sig_valid_o(tsv), .tx_sig_data_o(tsd),
      .tx_sig_ready_i(tsr), .sclk_rate_fast_o(fast), .stack_access_enable_o(sae), .bit_strobe_o(bs),
      .tx_line_plus_o(lp), .tx_line_minus_o(lm), .tx_optical_data_o(lo));
   fahp_checker fahp_checker_inst (.sys_clk_i(sys_clk), .resetn_i(resetn), .addr_i(bus_if.addr),
      .chip_select_n_i(bus_if.chip_select_n), .read_strobe_n_i(bus_if.read_strobe_n),
      .write_strobe_n_i(bus_if.write_strobe_n), .stack_ack_n_i(bus_if.stack_ack_n),
      .host_data_oe_i(bus_if.host_data_oe), .dev_data_oe_i(bus_if.dev_data_oe),
      .dev_data_out_i(bus_if.dev_data_out));
   // 125 MHz system clock
   always #4 sys_clk = ~sys_clk;
   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
      total_checks++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask : chk
   task automatic wrap_up;
      $display("checks %0d errors %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : wrap_up
   // one host command; ready is high in idle, so it is taken at the next edge
   task automatic cmd(input logic w, input logic s, input logic [3:0] a, input logic [7:0] d);
      int n;
      @(negedge sys_clk);
      chk({7'h0, rdy}, 8'h01, "ready in idle");
      cv = 1'b1;
      cw = w;
      cst = s;
      ca = a;
      cd = d;
      @(negedge sys_clk);
      cv = 1'b0;
      n = 0;
      while (rv !== 1'b1 && n < 20) begin
         @(negedge sys_clk);
         n++;
      end
      // a full cycle answers after setup, strobe and hold; a refused write at once
      if (n == 20) chk(8'h00, 8'h01, "no response");
      else if (re !== 1'b1) chk(8'(n), 8'(SETUP_CYCLES + STROBE_CYCLES + HOLD_CYCLES), "latency");
      r_err = re;
      r_dat = rdat;
   endtask : cmd
   task automatic rd(input logic [3:0] a, input logic s, input logic [7:0] exp);
      cmd(1'b0, s, a, 8'h00);
      chk(r_dat, exp, "read data");
   endtask : rd
   // bounded wait for a bit strobe, then let the line flops settle
   task automatic wait_bs;
      int n;
      n = 0;
      @(negedge sys_clk);
      while (bs !== 1'b1 && n < 200) begin
         @(negedge sys_clk);
         n++;
      end
      if (n == 200) chk(8'h00, 8'h01, "no bit strobe");
      @(negedge sys_clk);
   endtask : wait_bs
   // aligns to one route clock edge, then counts cycles to the next
   task automatic half(input logic [7:0] exp);
      int n;
      logic v;
      for (int k = 0; k < 2; k++) begin
         v = bus_if.rx_route_clock;
         n = 0;
         while (bus_if.rx_route_clock === v && n < 100) begin
            @(negedge sys_clk);
            n++;
         end
      end
      chk(8'(n), exp, "route half period");
   endtask : half
   // main sequence
   initial begin
      {e1, cv, cw, cst, cos, tp, tm, to, rsv, tsr} = 10'h200;
      ca = 4'h0; cd = 8'h00; rsd = 8'h00;
      repeat (2) @(posedge sys_clk);
      @(negedge sys_clk);
      resetn = 1'b1;
      rd(4'h0, 1'b0, 8'h00);
      for (int i = 0; i < 14; i++) cmd(1'b1, 1'b0, 4'(i), 8'(8'hA0 + i));
      chk({7'h0, r_err}, 8'h00, "write error");
      for (int i = 0; i < 14; i++) rd(4'(i), 1'b0, 8'(8'hA0 + i));
      chk({6'h0, fast, sae}, 8'h01, "mode outputs");
      cmd(1'b1, 1'b0, 4'h0, 8'h01);
      chk({7'h0, fast}, 8'h01, "fast rate");
      rd(4'hF, 1'b0, 8'h02);
      // refused writes leave the status places alone
      for (int i = 14; i < 16; i++) begin
         cmd(1'b1, 1'b0, 4'(i), 8'h55);
         chk({7'h0, r_err}, 8'h01, "refused write");
      end
      rd(4'hE, 1'b0, 8'h00);
      // stack traffic, access enabled by the control write above
      @(negedge sys_clk);
      chk({7'h0, rsr}, 8'h01, "rx stack ready");
      rsv = 1'b1;
      rsd = 8'h5A;
      @(negedge sys_clk);
      rsv = 1'b0;
      rd(4'hE, 1'b0, 8'h10);
      rd(4'h0, 1'b1, 8'h5A);
      rd(4'hE, 1'b0, 8'h00);
      cmd(1'b1, 1'b1, 4'h0, 8'h3C);
      chk({tsv, 7'h0}, 8'h80, "tx stack valid");
      chk(tsd, 8'h3C, "tx stack data");
      rd(4'hE, 1'b0, 8'h01);
      tsr = 1'b1;
      @(negedge sys_clk);
      tsr = 1'b0;
      // five pushes into a four-deep stack: the fifth is dropped and the head survives
      for (int i = 0; i < 5; i++) cmd(1'b1, 1'b1, 4'h0, 8'(8'h11 + i));
      rd(4'hE, 1'b0, 8'h04);
      chk(tsd, 8'h11, "full stack head");
      tsr = 1'b1;
      repeat (4) @(negedge sys_clk);
      tsr = 1'b0;
      cmd(1'b1, 1'b0, 4'h1, 8'h00);
      cmd(1'b1, 1'b1, 4'h0, 8'h77);
      chk({6'h0, sae, tsv}, 8'h00, "stack disabled");
      // out of service: alternating marks, optical held at one
      cos = 1'b1;
      rd(4'hF, 1'b0, 8'h03);
      wait_bs();
      p = lp;
      for (int i = 0; i < 4; i++) begin
         wait_bs();
         chk({5'h0, lp, lm, lo}, {5'h0, ~p, p, 1'b1}, "alarm pattern");
         p = ~p;
      end
      cos = 1'b0;
      tp = 1'b1;
      wait_bs();
      wait_bs();
      chk({5'h0, lp, lm, lo}, 8'h04, "framer copy");
      half(8'h1E);
      e1 = 1'b0;
      half(8'h28);
      wrap_up();
   end
   // watchdog well beyond the expected thousand or so cycles
   initial begin
      #100000;
      errors++;
      $display("[FAIL] %0t watchdog expired", $time);
      wrap_up();
   end
endmodule : fahp_tb
